// *** pmc_defs.vh ***
// constants for the power mode control block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
// register byte addresses
`define PMC_ADDR_CTRL 8'h00
`define PMC_ADDR_IRQ_STAT 8'h04
`define PMC_ADDR_IRQ_MASK 8'h08
`define PMC_ADDR_STATE 8'h0C
// power_mode_control field positions
`define PMC_BIT_SMOD 7
`define PMC_BIT_FESEL 6
`define PMC_BIT_OSC_FAIL_FLAG 5
`define PMC_BIT_OSC_FAIL_ENABLE 4
`define PMC_BIT_GF1 3
`define PMC_BIT_GF0 2
`define PMC_BIT_STOP 1
`define PMC_BIT_IDLE 0
`define PMC_CTRL_RESET 8'h00
// interrupt status field positions
`define PMC_EV_STOP 0
`define PMC_EV_WAKE 1
`define PMC_EV_OSC 2
`define PMC_EV_REFUSED 3
`define PMC_EV_W 4
// state readback field positions
`define PMC_ST_HALT 0
`define PMC_ST_STOP 1
`define PMC_ST_IDLE 2
`define PMC_ST_CAN 3
// number of serial ports whose bit 7 is steered
`define PMC_SER_PORTS 3
// ahb transfer type and size
`define PMC_HTRANS_NONSEQ 2'h2
`define PMC_HSIZE_WORD 3'h2
`endif

// *** pmc_sync.v ***
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module pmc_sync #(
  parameter W = 4
) (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // levels
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // first stage feeds only the second
  always @(posedge i_mclk) begin
    if (i_rst) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// *** pmc_power_ctrl.v ***
// power mode control register with ahb-lite slave and interrupts
// ----------------------------------------------------------------
// Functional notes
// R1 - select 0: bit 7 is mode bit
// R2 - select 1: bit 7 is framing flag
// R3 - stop bit halts core, oscillator, timers
// R4 - reset or interrupt clears stop, resumes
// R5 - stop bit always reads zero
// R6 - software must not stop while idle
// R7 - stop refused while any can active
// R8 - software readies cans before stopping
// R9 - idle halts core; interrupt resumes
// R10 - osc fail flag: hardware sets, software clears
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_power_ctrl (
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // ahb-lite slave
  input wire i_hsel,
  input wire [7:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // can module state pins, per module
  input wire [1:0] i_can_reset_ctrl,
  input wire [1:0] i_can_software_init,
  input wire [1:0] i_can_power_down_enable,
  // wake and oscillator monitor pins
  input wire i_ext_int_wake,
  input wire i_any_int_wake,
  input wire i_osc_fail_detect,
  // serial port bit 7 sources
  input wire [2:0] i_framing_error_flag,
  input wire [2:0] i_serial_mode_bit0,
  output reg [2:0] o_serial_ctrl_bit7,
  // power state outputs
  output reg o_core_halt,
  output reg o_osc_halt,
  output reg o_timer_halt,
  output reg o_baud_double,
  output reg o_irq
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // every can, wake and oscillator pin level lands two edges late; the outputs that react
  // to it follow one edge after that, so a wake costs three edges
  // in total from pin to halt release
  wire [8:0] sync_out;
  pmc_sync #(.W(9)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_can_reset_ctrl, i_can_software_init,
      i_can_power_down_enable, i_ext_int_wake, i_any_int_wake,
      i_osc_fail_detect}),
    .o_sync(sync_out)
  );
  wire [1:0] can_rst_s = sync_out[8:7];
  wire [1:0] can_init_s = sync_out[6:5];
  wire [1:0] can_pde_s = sync_out[4:3];
  wire ext_wake_s = sync_out[2];
  wire any_wake_s = sync_out[1];
  wire osc_fail_s = sync_out[0];

  // can counts as active when all its controls are zero
  function can_active;
    input r;
    input s;
    input p;
    begin
      can_active = ~(r | s | p);
    end
  endfunction

  wire can0_act = can_active(can_rst_s[0], can_init_s[0], can_pde_s[0]);
  wire can1_act = can_active(can_rst_s[1], can_init_s[1], can_pde_s[1]);
  wire any_can_act = can0_act | can1_act; // R7

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl;
  reg stop_mode;
  reg [`PMC_EV_W-1:0] irq_stat;
  reg [`PMC_EV_W-1:0] irq_mask;
  reg [7:0] addr_q;
  reg wr_q;
  reg rd_q;

  // ----------------------------------------------------------------
  // ahb-lite slave decode
  // ----------------------------------------------------------------
  // only whole-word nonseq transfers are taken; anything else is
  // ignored, so a byte write never half-updates the control bits
  // ahb address phase decode
  wire take = i_hsel & i_hready & (i_htrans == `PMC_HTRANS_NONSEQ) &
    (i_hsize == `PMC_HSIZE_WORD);

  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  wire wr_ctrl = wr_q & is_addr(addr_q, `PMC_ADDR_CTRL);
  wire wr_mask = wr_q & is_addr(addr_q, `PMC_ADDR_IRQ_MASK);
  wire rd_stat = rd_q & is_addr(addr_q, `PMC_ADDR_IRQ_STAT);

  // ----------------------------------------------------------------
  // power mode requests
  // ----------------------------------------------------------------
  // stop while idle is left undefined; software must avoid it, and
  // this logic clears each mode only on its own wake, so the core stays halted until both wakes
  // stop request: refused while any can active
  wire stop_req = wr_ctrl & i_hwdata[`PMC_BIT_STOP] & ~any_can_act; // R7
  wire stop_refused = wr_ctrl & i_hwdata[`PMC_BIT_STOP] & any_can_act;
  wire idle_req = wr_ctrl & i_hwdata[`PMC_BIT_IDLE];
  wire stop_wake = stop_mode & ext_wake_s; // R4
  wire idle_wake = ctrl[`PMC_BIT_IDLE] & any_wake_s; // R9
  // fail flag only when not deliberately stopped
  wire osc_fail_set = ctrl[`PMC_BIT_OSC_FAIL_ENABLE] & osc_fail_s &
    ~stop_mode; // R10

  // ----------------------------------------------------------------
  // bus pipeline
  // ----------------------------------------------------------------
  // the data phase decodes from the address held here
  // capture address phase
  always @(posedge i_mclk) begin
    if (i_rst) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      addr_q <= i_haddr;
      wr_q <= take & i_hwrite;
      rd_q <= take & ~i_hwrite;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // the stop bit is never stored; stop_mode carries the state so a
  // read of the register can only ever show zero there
  // control register, stop and idle state
  always @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl <= `PMC_CTRL_RESET; // R4
      stop_mode <= 1'b0;
    end else begin
      // select, enable and user flags are plain software bits
      if (wr_ctrl) begin
        ctrl[`PMC_BIT_SMOD] <= i_hwdata[`PMC_BIT_SMOD];
        ctrl[`PMC_BIT_FESEL] <= i_hwdata[`PMC_BIT_FESEL];
        ctrl[`PMC_BIT_OSC_FAIL_ENABLE] <= i_hwdata[`PMC_BIT_OSC_FAIL_ENABLE];
        ctrl[`PMC_BIT_GF1] <= i_hwdata[`PMC_BIT_GF1];
        ctrl[`PMC_BIT_GF0] <= i_hwdata[`PMC_BIT_GF0];
      end
      // hardware set wins over software clear
      if (osc_fail_set)
        ctrl[`PMC_BIT_OSC_FAIL_FLAG] <= 1'b1; // R10
      else if (wr_ctrl & ~i_hwdata[`PMC_BIT_OSC_FAIL_FLAG])
        ctrl[`PMC_BIT_OSC_FAIL_FLAG] <= 1'b0; // R10
      // idle set by software, cleared by interrupt
      if (idle_wake)
        ctrl[`PMC_BIT_IDLE] <= 1'b0; // R9
      else if (idle_req)
        ctrl[`PMC_BIT_IDLE] <= 1'b1; // R9
      // stop bit slot stays clear whatever was written
      ctrl[`PMC_BIT_STOP] <= 1'b0;
      if (stop_wake)
        stop_mode <= 1'b0; // R4
      else if (stop_req)
        stop_mode <= 1'b1; // R3
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // sticky events, read clears, set wins
  wire [`PMC_EV_W-1:0] ev;
  assign ev[`PMC_EV_STOP] = stop_req;
  assign ev[`PMC_EV_WAKE] = stop_wake | idle_wake;
  assign ev[`PMC_EV_OSC] = osc_fail_set & ~ctrl[`PMC_BIT_OSC_FAIL_FLAG];
  assign ev[`PMC_EV_REFUSED] = stop_refused;
  // read clear applied first so an event in the clearing cycle stays
  wire [`PMC_EV_W-1:0] next_irq_stat =
    (rd_stat ? {`PMC_EV_W{1'b0}} : irq_stat) | ev;
  wire [`PMC_EV_W-1:0] next_irq_mask =
    wr_mask ? i_hwdata[`PMC_EV_W-1:0] : irq_mask;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      irq_stat <= {`PMC_EV_W{1'b0}};
      irq_mask <= {`PMC_EV_W{1'b0}};
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // decoded from the live address so the word is ready one edge on
  // read mux for the data phase
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (i_haddr)
      `PMC_ADDR_CTRL: begin
        next_rdata[7:0] = ctrl;
        next_rdata[`PMC_BIT_STOP] = 1'b0; // R5
      end
      `PMC_ADDR_IRQ_STAT: next_rdata[`PMC_EV_W-1:0] = irq_stat;
      `PMC_ADDR_IRQ_MASK: next_rdata[`PMC_EV_W-1:0] = irq_mask;
      `PMC_ADDR_STATE: begin
        next_rdata[`PMC_ST_HALT] = o_core_halt;
        next_rdata[`PMC_ST_STOP] = stop_mode;
        next_rdata[`PMC_ST_IDLE] = ctrl[`PMC_BIT_IDLE];
        next_rdata[`PMC_ST_CAN] = any_can_act;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  // ready is low only in reset, so no transfer starts too early
  // bus outputs: zero wait state, always okay
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b0;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (take & ~i_hwrite)
        o_hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // power state and serial outputs
  // ----------------------------------------------------------------
  // each port picks its framing flag or its mode bit by the select
  wire [`PMC_SER_PORTS-1:0] next_bit7;
  genvar gp;
  generate
    for (gp = 0; gp < `PMC_SER_PORTS; gp = gp + 1) begin : g_bit7
      assign next_bit7[gp] = ctrl[`PMC_BIT_FESEL] ?
        i_framing_error_flag[gp] : // R2
        i_serial_mode_bit0[gp]; // R1
    end
  endgenerate

  // halts follow the next mode state so they never lag a request
  // power state and serial bit 7 outputs
  wire stop_next = stop_wake ? 1'b0 : (stop_req | stop_mode);
  wire idle_next = idle_wake ? 1'b0 :
    (idle_req | ctrl[`PMC_BIT_IDLE]);
  wire irq_next = |(next_irq_stat & next_irq_mask);
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_core_halt <= 1'b0;
      o_osc_halt <= 1'b0;
      o_timer_halt <= 1'b0;
      o_baud_double <= 1'b0;
      o_serial_ctrl_bit7 <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      o_core_halt <= stop_next | idle_next; // R3
      o_osc_halt <= stop_next; // R3
      o_timer_halt <= stop_next; // R3
      o_baud_double <= ctrl[`PMC_BIT_SMOD];
      o_serial_ctrl_bit7 <= next_bit7; // R1 R2
      o_irq <= irq_next;
    end
  end
endmodule

// *** pmc_asserts.sv ***
// concurrent checks for the power mode control block
`timescale 1ns/1ps
module pmc_asserts (
  // clock, reset and bus
  input wire i_mclk, i_rst, i_hsel, i_hwrite, i_hready,
  input wire o_hreadyout, o_hresp,
  input wire [7:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata, o_hrdata,
  // can, wake and power pins
  input wire [1:0] i_can_reset_ctrl, i_can_software_init,
  input wire [1:0] i_can_power_down_enable,
  input wire i_ext_int_wake, i_any_int_wake,
  input wire o_core_halt, o_osc_halt, o_timer_halt,
  input wire [2:0] i_framing_error_flag, i_serial_mode_bit0,
  input wire [2:0] o_serial_ctrl_bit7
);
  // bus phase tracking and select shadow
  reg wp, rp, fs;
  wire t = i_hsel && i_hready && i_htrans == 2'h2 && i_hsize == 3'h2
    && i_haddr == 8'h00;
  wire act = |(~(i_can_reset_ctrl | i_can_software_init
    | i_can_power_down_enable));
  always @(posedge i_mclk) begin
    wp <= t && i_hwrite;
    rp <= t && !i_hwrite;
    fs <= i_rst ? 1'b0 : (wp ? i_hwdata[6] : fs);
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_bit7_source: assert property (!$past(i_rst) |->
    o_serial_ctrl_bit7 == ($past(fs) ? $past(i_framing_error_flag)
    : $past(i_serial_mode_bit0))) else $error("serial bit 7 source");
  chk_stop_halts: assert property (o_osc_halt |->
    o_core_halt && o_timer_halt) else $error("stop without halts");
  chk_reset_runs: assert property ($past(i_rst) |->
    !o_osc_halt && !o_core_halt) else $error("halted after reset");
  chk_stop_wake: assert property (o_osc_halt && i_ext_int_wake |->
    ##[1:4] !o_osc_halt) else $error("stop not left on wake");
  chk_stop_reads: assert property (rp |-> !o_hrdata[1])
    else $error("stop bit read as one");
  chk_can_refuse: assert property (act[*4] ##0 !o_osc_halt
    |=> !o_osc_halt) else $error("stop taken with can active");
  chk_idle_wake: assert property (o_core_halt && !o_osc_halt
    && i_any_int_wake |-> ##[1:4] !o_core_halt) else $error("idle stuck");
  chk_resp_okay: assert property (!o_hresp) else $error("bad response");
  chk_ready_up: assert property (!i_rst |=> o_hreadyout)
    else $error("ready low");
endmodule
bind pmc_power_ctrl pmc_asserts u_chk (.*);

// *** power_control_register_bench.sv ***
// self-checking bench for the power mode control block
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module power_control_register_bench;
  // stimulus and observed pins
  reg i_mclk = 0, i_rst = 1, hs = 0, hw = 0, xw = 0, aw = 0, od = 0;
  reg rp = 0;
  reg [7:0] ha = 0;
  reg [1:0] ht = 0, cc = 0, cs = 0, cp = 0;
  reg [2:0] fe = 0, sm = 0;
  reg [31:0] wd = 0, e;
  wire [31:0] rd;
  wire rdy, resp, ch, oh, th, bd, irq;
  wire [2:0] s7;
  int failures = 0, cmp_count = 0, n, i;
  logic [31:0] q[$];
  pmc_power_ctrl dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hs),
    .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2),
    .i_hwdata(wd), .i_hready(rdy), .o_hrdata(rd), .o_hreadyout(rdy),
    .o_hresp(resp), .i_can_reset_ctrl(cc), .i_can_software_init(cs),
    .i_can_power_down_enable(cp), .i_ext_int_wake(xw),
    .i_any_int_wake(aw), .i_osc_fail_detect(od),
    .i_framing_error_flag(fe), .i_serial_mode_bit0(sm),
    .o_serial_ctrl_bit7(s7), .o_core_halt(ch), .o_osc_halt(oh),
    .o_timer_halt(th), .o_baud_double(bd), .o_irq(irq));
  // clock
  initial forever #50 i_mclk = ~i_mclk;
  // read data checker fed by the queue
  always @(posedge i_mclk) if (rp && rdy) begin
    e = q.pop_front();
    `CHK(rd, e)
  end
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for ready at a rising edge
  task wrdy;
    n = 0;
    do begin @(posedge i_mclk); n++; end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin failures++; finish_test; end
  endtask
  // one word transfer; for reads d is the expected word
  task bus(input [7:0] a, input w, input [31:0] d);
    @(posedge i_mclk);
    hs <= 1; ha <= a; ht <= 2'h2; hw <= w;
    wrdy;
    ht <= 0; wd <= d; rp <= !w;
    if (!w) q.push_back(d);
    wrdy;
    rp <= 0; hs <= 0;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge i_mclk);
  endtask
  // main sequence
  initial begin
    i = $urandom(32'hC4AA22F9);
    repeat (2) @(posedge i_mclk);
    i_rst <= 0;
    bus(8'h00, 0, 32'h0);
    bus(8'h0C, 0, 32'h8);
    $display("test reset end");
    for (i = 0; i < 16; i++) begin
      if (i % 8 == 0) bus(8'h00, 1, (i / 8) << 6);
      fe <= $urandom; sm <= $urandom;
      cyc(2);
      `CHK(s7, (i >= 8) ? fe : sm)
    end
    $display("test serial end");
    bus(8'h08, 1, 32'hF);
    bus(8'h00, 1, 32'h0E);
    bus(8'h00, 0, 32'h0C);
    `CHK({oh, irq}, 2'h1)
    bus(8'h04, 0, 32'h8);
    bus(8'h04, 0, 32'h0);
    `CHK(irq, 1'b0)
    $display("test refuse end");
    cc <= 2'h3;
    cyc(4);
    bus(8'h00, 1, 32'h02);
    cyc(3);
    `CHK({oh, ch, th, irq}, 4'hF)
    bus(8'h0C, 0, 32'h3);
    xw <= 1; cyc(5); xw <= 0;
    `CHK({oh, ch}, 2'h0)
    bus(8'h04, 0, 32'h3);
    $display("test stop end");
    bus(8'h00, 1, 32'h01);
    cyc(2);
    `CHK({oh, ch}, 2'h1)
    aw <= 1; cyc(5); aw <= 0;
    `CHK(ch, 1'b0)
    bus(8'h00, 1, 32'h10);
    od <= 1; cyc(4); od <= 0;
    bus(8'h00, 0, 32'h30);
    bus(8'h00, 1, 32'h10);
    bus(8'h00, 0, 32'h10);
    bus(8'h10, 1, 32'hFF);
    bus(8'h10, 0, 32'h0);
    bus(8'h00, 1, 32'h80);
    cyc(2);
    `CHK(bd, 1'b1)
    $display("test idle osc end");
    finish_test;
  end
endmodule
